// *** bench/adc_config_regs_props.sv ***
/*
  Port assertions of the configuration bank, ref_clk domain.
  Assumes binding to every adc_config_regs instance.
*/
`timescale 1ns/1ns
module adc_config_regs_props (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic reset_pin_low,
    input wire logic power_down_pin,
    input wire logic serial_clk,
    input wire logic serial_select_low,
    input wire logic serial_data_in,
    input wire logic [7:0] conversion_data,
    input wire adc_cfg_pkg::config_t config_out,
    input wire adc_cfg_pkg::lvds_code_t term_applied,
    input wire logic device_sleep,
    input wire logic device_power_down,
    input wire logic [7:0] output_data,
    input wire logic output_is_pattern
);
    import adc_cfg_pkg::*;
    logic [4:0] idle_reg;
    logic [4:0] idle_next;
    logic any_pat;
    logic alt_only;
    assign any_pat = config_out.ramp_enable | config_out.alternate_enable
        | config_out.constant_enable;
    assign alt_only = config_out.alternate_enable & ~config_out.ramp_enable;
    // Counts quiet ref cycles; config may only move shortly after a frame
    always_comb begin
        idle_next = idle_reg;
        if (!serial_select_low)
            idle_next = 5'h00;
        else if (idle_reg != 5'h1F)
            idle_next = idle_reg + 5'h01;
    end
    always_ff @(posedge ref_clk) begin
        if (reset)
            idle_reg <= 5'h00;
        else
            idle_reg <= idle_next;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_defaults;
        $fell(reset) |-> config_out == '0 && !output_is_pattern;
    endproperty
    a_defaults: assert property (p_defaults) else $error("config not at defaults");
    property p_term;
        1'b1 |=> term_applied == ($past(config_out.term_enable) ? $past(config_out.term) : '0);
    endproperty
    a_term: assert property (p_term) else $error("termination gating wrong");
    property p_sleep;
        config_out.sleep_bit |=> device_sleep;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep bit ignored");
    property p_power;
        config_out.power_down_bit |=> device_power_down;
    endproperty
    a_power: assert property (p_power) else $error("power-down bit ignored");
    property p_pin_ignored;
        config_out.powerdown_pin_function[1] && !config_out.sleep_bit
            && !config_out.power_down_bit |=> !device_sleep && !device_power_down;
    endproperty
    a_pin_ignored: assert property (p_pin_ignored) else $error("pin not ignored");
    property p_flag;
        1'b1 |=> output_is_pattern == $past(any_pat);
    endproperty
    a_flag: assert property (p_flag) else $error("pattern flag wrong");
    property p_pass;
        !any_pat |=> output_data == $past(conversion_data);
    endproperty
    a_pass: assert property (p_pass) else $error("conversion data lost");
    property p_const;
        config_out.constant_enable && !config_out.ramp_enable && !config_out.alternate_enable
            |=> output_data == $past(config_out.pattern_code_a);
    endproperty
    a_const: assert property (p_const) else $error("constant code wrong");
    property p_alt;
        alt_only ##1 alt_only |=> output_data == (($past(output_data) ==
            $past(config_out.pattern_code_a)) ? $past(config_out.pattern_code_b)
            : $past(config_out.pattern_code_a));
    endproperty
    a_alt: assert property (p_alt) else $error("alternate code wrong");
    property p_ramp;
        config_out.ramp_enable [*2] |=> output_data == $past(output_data) + 8'h01;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp step wrong");
    property p_idle;
        idle_reg >= 5'h0C && reset_pin_low |-> $stable(config_out);
    endproperty
    a_idle: assert property (p_idle) else $error("config moved without frame");
endmodule

bind adc_config_regs adc_config_regs_props u_props (.ref_clk(ref_clk), .reset(reset),
    .reset_pin_low(reset_pin_low), .power_down_pin(power_down_pin),
    .serial_clk(serial_clk), .serial_select_low(serial_select_low),
    .serial_data_in(serial_data_in), .conversion_data(conversion_data),
    .config_out(config_out), .term_applied(term_applied), .device_sleep(device_sleep),
    .device_power_down(device_power_down), .output_data(output_data),
    .output_is_pattern(output_is_pattern));

// *** bench/adc_config_regs_tb_top.sv ***
/*
  Self-checking bench of the configuration bank, writes through the host model.
  Assumes the design settles a frame within 12 ref cycles.
*/
`timescale 1ns/1ns
module adc_config_regs_tb_top;
    import adc_cfg_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic reset_pin_low = 1'b1;
    logic power_down_pin = 1'b0;
    logic [7:0] conversion_data = 8'h3C;
    logic serial_clk;
    logic serial_select_low;
    logic serial_data_in;
    config_t cfg;
    lvds_code_t term_applied;
    logic device_sleep;
    logic device_power_down;
    logic output_is_pattern;
    logic [7:0] output_data;
    logic [7:0] prev;
    logic [15:0] pin_word [3] = '{16'h0400, 16'h0000, 16'h0800};
    logic [1:0] pin_exp [3] = '{2'b10, 2'b01, 2'b00};
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    always #5 ref_clk = ~ref_clk;
    serial_host_model host (.serial_clk(serial_clk), .serial_select_low(serial_select_low),
        .serial_data_in(serial_data_in));
    adc_config_regs DUT (.ref_clk(ref_clk), .reset(reset), .reset_pin_low(reset_pin_low),
        .power_down_pin(power_down_pin), .serial_clk(serial_clk),
        .serial_select_low(serial_select_low), .serial_data_in(serial_data_in),
        .conversion_data(conversion_data), .config_out(cfg), .term_applied(term_applied),
        .device_sleep(device_sleep), .device_power_down(device_power_down),
        .output_data(output_data), .output_is_pattern(output_is_pattern));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Ends on a falling edge so outputs are settled when read
    task automatic put(input logic [7:0] a, input logic [15:0] d, input int n = 24);
        host.send(a, d, n);
        repeat (12) @(negedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(negedge ref_clk);
        check("cfg", {15'h0, |cfg}, 16'h0);
        check("flags", {13'h0, device_sleep, device_power_down, output_is_pattern}, 16'h0);
        $display("Test reset done");
        put(8'h0F, 16'h0200);
        check("pd_on", {15'h0, device_power_down}, 16'h1);
        put(8'h0F, 16'h0000);
        check("pd_off", {15'h0, device_power_down}, 16'h0);
        put(8'h0F, 16'h017F);
        check("doze", {9'h0, cfg.single_channel_doze, cfg.dual_channel_doze,
            cfg.quad_channel_doze}, 16'h007F);
        check("sleep", {15'h0, device_sleep}, 16'h1);
        @(posedge ref_clk);
        power_down_pin <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            put(8'h0F, pin_word[i]);
            check("pinf", {14'h0, cfg.powerdown_pin_function}, {14'h0, pin_word[i][11:10]});
            check("pin", {14'h0, device_sleep, device_power_down}, {14'h0, pin_exp[i]});
        end
        @(posedge ref_clk);
        power_down_pin <= 1'b0;
        $display("Test power done");
        put(8'h11, 16'h0536);
        check("drive", {7'h0, cfg.drive}, {7'h0, 3'h6, 3'h3, 3'h5});
        put(8'h12, 16'h0257);
        check("term_off", {7'h0, term_applied}, 16'h0);
        put(8'h12, 16'h4257);
        check("term_on", {6'h0, cfg.term_enable, term_applied}, {7'h1, 3'h7, 3'h5, 3'h2});
        put(8'h24, 16'h005A);
        check("swap", {9'h0, cfg.single_input_swap, cfg.dual_input_swap,
            cfg.quad_input_swap}, 16'h005A);
        $display("Test lanes done");
        put(8'h26, 16'hA53C);
        put(8'h27, 16'h5A00);
        check("codes", {cfg.pattern_code_a, cfg.pattern_code_b}, 16'hA55A);
        put(8'h25, 16'h0010);
        check("const", {7'h0, output_is_pattern, output_data}, 16'h01A5);
        put(8'h25, 16'h0020);
        prev = output_data;
        @(negedge ref_clk);
        check("alt", {8'h0, output_data ^ prev}, 16'h00FF);
        put(8'h25, 16'h0040);
        prev = output_data;
        @(negedge ref_clk);
        check("ramp", {8'h0, output_data - prev}, 16'h0001);
        put(8'h25, 16'h0000);
        check("pass", {7'h0, output_is_pattern, output_data}, 16'h003C);
        @(posedge ref_clk);
        conversion_data <= 8'hC3;
        repeat (2) @(negedge ref_clk);
        check("pass2", {8'h0, output_data}, 16'h00C3);
        $display("Test patterns done");
        put(8'h2A, 16'h1234);
        check("gain", cfg.quad_gain, 16'h1234);
        put(8'h13, 16'hFFFF);
        put(8'h2A, 16'h5555, 12);
        check("gain_kept", cfg.quad_gain, 16'h1234);
        put(8'h2A, 16'hBEEF, 30);
        check("gain_long", cfg.quad_gain, 16'hBEEF);
        $display("Test frames done");
        put(8'h00, 16'h0001);
        check("soft", {15'h0, |cfg}, 16'h0);
        put(8'h2A, 16'h0F0F);
        @(posedge ref_clk);
        reset_pin_low <= 1'b0;
        repeat (10) @(posedge ref_clk);
        reset_pin_low <= 1'b1;
        repeat (8) @(negedge ref_clk);
        check("pin_rst", {15'h0, |cfg}, 16'h0);
        $display("Test resets done");
        results();
    end
endmodule

// *** bench/serial_host_model.sv ***
/*
  Host model for the three-wire write port: sends frames MSB first.
  Assumes the bench calls send and gives it the bit count.
*/
`timescale 1ns/1ns
module serial_host_model (
    output logic serial_clk,
    output logic serial_select_low,
    output logic serial_data_in
);
    initial begin
        serial_clk = 1'b0;
        serial_select_low = 1'b1;
        serial_data_in = 1'b0;
    end
    // Link clock of 125 ns runs only inside a frame
    task automatic send(input logic [7:0] a, input logic [15:0] d, input int n);
        logic [23:0] word;
        word = {a, d};
        serial_select_low = 1'b0;
        #23;
        for (int i = 0; i < n; i++) begin
            serial_data_in = (i < 24) ? word[23 - i] : ~serial_data_in;
            #62 serial_clk = 1'b1;
            #63 serial_clk = 1'b0;
        end
        #20 serial_select_low = 1'b1;
        // Released line must not keep the last bit
        serial_data_in = ~serial_data_in;
        #250;
    endtask
endmodule

// *** design/adc_cfg_pkg.sv ***
/*
  Shared constants and types of the converter configuration register bank:
  register offsets, field positions, reset values, serial frame layout and
  synchroniser depth. Assumes nothing of its surroundings.
*/
package adc_cfg_pkg;

    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 16;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] FRAME_FULL = 5'h18;
    localparam int SYNC_STAGES = 3;

    localparam logic [7:0] SOFT_RESET_CTRL_ADDR = 8'h00;
    localparam logic [7:0] POWER_STATE_CTRL_ADDR = 8'h0F;
    localparam logic [7:0] OUTPUT_DRIVE_CTRL_ADDR = 8'h11;
    localparam logic [7:0] OUTPUT_TERMINATION_CTRL_ADDR = 8'h12;
    localparam logic [7:0] INPUT_POLARITY_CTRL_ADDR = 8'h24;
    localparam logic [7:0] TEST_PATTERN_CTRL_ADDR = 8'h25;
    localparam logic [7:0] PATTERN_CODE_FIRST_ADDR = 8'h26;
    localparam logic [7:0] PATTERN_CODE_SECOND_ADDR = 8'h27;
    localparam logic [7:0] QUAD_GAIN_CTRL_ADDR = 8'h2A;

    localparam int SOFT_RESET_POS = 0;
    localparam int QUAD_LANE_POS = 0;
    localparam int DUAL_LANE_POS = 4;
    localparam int SINGLE_LANE_POS = 6;
    localparam int SLEEP_POS = 8;
    localparam int POWER_DOWN_POS = 9;
    localparam int PIN_FUNC_POS = 10;
    localparam int BIT_CLOCK_POS = 0;
    localparam int FRAME_CLOCK_POS = 4;
    localparam int DATA_LANES_POS = 8;
    localparam int TERM_ENABLE_POS = 14;
    localparam int RAMP_POS = 6;
    localparam int ALTERNATE_POS = 5;
    localparam int CONSTANT_POS = 4;
    localparam int CODE_POS = 8;
    localparam int GAIN_LANE_STRIDE = 4;

    localparam logic [2:0] DRIVE_DEFAULT = 3'h0;
    localparam logic [2:0] TERM_DEFAULT = 3'h0;
    localparam logic [3:0] GAIN_UNITY = 4'h0;
    localparam logic [7:0] CODE_DEFAULT = 8'h00;

    typedef enum logic [1:0] {
        PIN_POWER_DOWN = 2'b00,
        PIN_SLEEP = 2'b01,
        PIN_UNUSED_A = 2'b10,
        PIN_UNUSED_B = 2'b11
    } pin_func_t;

    typedef enum logic [1:0] {
        PAT_NONE = 2'b00,
        PAT_RAMP = 2'b01,
        PAT_ALTERNATE = 2'b10,
        PAT_CONSTANT = 2'b11
    } pattern_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } frame_t;

    typedef struct packed {
        logic [2:0] bit_clock;
        logic [2:0] frame_clock;
        logic [2:0] data_lanes;
    } lvds_code_t;

    typedef struct packed {
        logic [3:0] quad_channel_doze;
        logic [1:0] dual_channel_doze;
        logic single_channel_doze;
        logic sleep_bit;
        logic power_down_bit;
        pin_func_t powerdown_pin_function;
        lvds_code_t drive;
        logic term_enable;
        lvds_code_t term;
        logic [3:0] quad_input_swap;
        logic [1:0] dual_input_swap;
        logic single_input_swap;
        logic ramp_enable;
        logic alternate_enable;
        logic constant_enable;
        logic [7:0] pattern_code_a;
        logic [7:0] pattern_code_b;
        logic [15:0] quad_gain;
    } config_t;

endpackage

// *** design/adc_config_regs.sv ***
/*
  Configuration register bank of the interleaved converter, low part of the
  map: serial write port, soft and pin reset, power control, output drive
  and termination, input swap, test patterns and quad coarse gain.
  Assumes a host drives the three-wire port on its own serial clock, and
  that reset, power-down pin and conversion data arrive as listed below.

// Summary of operation
// - Frame is 8 address then 16 data
// - Sample on rising clock, commit at 24th
// - Reset bit restores defaults, then clears itself
// - Sleep bits per mode in power register
// - Two-bit field sets power-down pin function
// - Three drive-current codes, default 3.5 mA
// - Bit 14 enables termination, off after reset
// - Termination codes apply only when enabled
// - Per-mode input swap bits, clear keeps polarity
// - Ramp bit replaces output with full-scale ramp
// - Alternate bit toggles between two codes
// - Constant bit holds the first code
// - First code register, defaults to zero
// - Second code register, defaults to zero
// - Four quad gain nibbles, default unity
*/
`timescale 1ns/1ns
module adc_config_regs (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic reset_pin_low,
    input wire logic power_down_pin,
    input wire logic serial_clk,
    input wire logic serial_select_low,
    input wire logic serial_data_in,
    input wire logic [7:0] conversion_data,
    output adc_cfg_pkg::config_t config_out,
    output adc_cfg_pkg::lvds_code_t term_applied,
    output logic device_sleep,
    output logic device_power_down,
    output logic [7:0] output_data,
    output logic output_is_pattern
);
    import adc_cfg_pkg::*;

    frame_t link_frame;
    logic link_toggle;

    serial_frame_rx rx (
        .serial_clk(serial_clk),
        .link_reset(reset),
        .serial_select_low(serial_select_low),
        .serial_data_in(serial_data_in),
        .frame(link_frame),
        .frame_toggle(link_toggle)
    );

    // Three-stage synchronisers: toggle, reset pin, power-down pin
    localparam int NUM_SYNC = 3;
    logic [NUM_SYNC-1:0] sync_in;
    logic [NUM_SYNC-1:0] sync_idle;
    logic [NUM_SYNC-1:0] stage1_reg;
    logic [NUM_SYNC-1:0] stage2_reg;
    logic [NUM_SYNC-1:0] stage3_reg;
    logic [NUM_SYNC-1:0] agreed_reg;
    logic [NUM_SYNC-1:0] agreed_next;

    assign sync_in = {power_down_pin, reset_pin_low, link_toggle};
    assign sync_idle = {1'b0, 1'b1, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SYNC; gi = gi + 1) begin : g_sync
            always_comb begin
                agreed_next[gi] = agreed_reg[gi];
                // A change counts once the last two stages agree
                if (stage2_reg[gi] == stage3_reg[gi]) begin
                    agreed_next[gi] = stage3_reg[gi];
                end
            end
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    stage1_reg[gi] <= sync_idle[gi];
                    stage2_reg[gi] <= sync_idle[gi];
                    stage3_reg[gi] <= sync_idle[gi];
                    agreed_reg[gi] <= sync_idle[gi];
                end else begin
                    stage1_reg[gi] <= sync_in[gi];
                    stage2_reg[gi] <= stage1_reg[gi];
                    stage3_reg[gi] <= stage2_reg[gi];
                    agreed_reg[gi] <= agreed_next[gi];
                end
            end
        end
    endgenerate

    // Toggle and its seen copy both start at zero on reset; no false write
    logic toggle_seen_reg;
    logic toggle_seen_next;
    logic frame_arrived;
    logic pin_reset;
    logic pin_power;

    assign frame_arrived = agreed_reg[0] != toggle_seen_reg;
    assign pin_reset = ~agreed_reg[1];
    assign pin_power = agreed_reg[2];

    always_comb begin
        toggle_seen_next = agreed_reg[0];
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            toggle_seen_reg <= 1'b0;
        end else begin
            toggle_seen_reg <= toggle_seen_next;
        end
    end

    // Register file
    config_t cfg_reg;
    config_t cfg_next;
    config_t cfg_default;
    logic soft_reset_reg;
    logic soft_reset_next;
    logic [15:0] wdata;
    logic [7:0] waddr;

    assign waddr = link_frame.addr;
    assign wdata = link_frame.data;

    always_comb begin
        cfg_default = '0;
        cfg_default.powerdown_pin_function = PIN_POWER_DOWN;
        cfg_default.drive = '{DRIVE_DEFAULT, DRIVE_DEFAULT, DRIVE_DEFAULT};
        cfg_default.term_enable = 1'b0;
        cfg_default.term = '{TERM_DEFAULT, TERM_DEFAULT, TERM_DEFAULT};
        cfg_default.pattern_code_a = CODE_DEFAULT;
        cfg_default.pattern_code_b = CODE_DEFAULT;
        cfg_default.quad_gain = {GAIN_UNITY, GAIN_UNITY, GAIN_UNITY, GAIN_UNITY};
    end

    always_comb begin
        cfg_next = cfg_reg;
        soft_reset_next = 1'b0;
        if (soft_reset_reg) begin
            cfg_next = cfg_default;
        end else if (frame_arrived) begin
            if (waddr == SOFT_RESET_CTRL_ADDR) begin
                soft_reset_next = wdata[SOFT_RESET_POS];
            end else if (waddr == POWER_STATE_CTRL_ADDR) begin
                cfg_next.quad_channel_doze = wdata[QUAD_LANE_POS +: 4];
                cfg_next.dual_channel_doze = wdata[DUAL_LANE_POS +: 2];
                cfg_next.single_channel_doze = wdata[SINGLE_LANE_POS];
                cfg_next.sleep_bit = wdata[SLEEP_POS];
                cfg_next.power_down_bit = wdata[POWER_DOWN_POS];
                cfg_next.powerdown_pin_function = pin_func_t'(wdata[PIN_FUNC_POS +: 2]);
            end else if (waddr == OUTPUT_DRIVE_CTRL_ADDR) begin
                cfg_next.drive.bit_clock = wdata[BIT_CLOCK_POS +: 3];
                cfg_next.drive.frame_clock = wdata[FRAME_CLOCK_POS +: 3];
                cfg_next.drive.data_lanes = wdata[DATA_LANES_POS +: 3];
            end else if (waddr == OUTPUT_TERMINATION_CTRL_ADDR) begin
                cfg_next.term_enable = wdata[TERM_ENABLE_POS];
                cfg_next.term.bit_clock = wdata[BIT_CLOCK_POS +: 3];
                cfg_next.term.frame_clock = wdata[FRAME_CLOCK_POS +: 3];
                cfg_next.term.data_lanes = wdata[DATA_LANES_POS +: 3];
            end else if (waddr == INPUT_POLARITY_CTRL_ADDR) begin
                cfg_next.quad_input_swap = wdata[QUAD_LANE_POS +: 4];
                cfg_next.dual_input_swap = wdata[DUAL_LANE_POS +: 2];
                cfg_next.single_input_swap = wdata[SINGLE_LANE_POS];
            end else if (waddr == TEST_PATTERN_CTRL_ADDR) begin
                cfg_next.ramp_enable = wdata[RAMP_POS];
                cfg_next.alternate_enable = wdata[ALTERNATE_POS];
                cfg_next.constant_enable = wdata[CONSTANT_POS];
            end else if (waddr == PATTERN_CODE_FIRST_ADDR) begin
                cfg_next.pattern_code_a = wdata[CODE_POS +: 8];
            end else if (waddr == PATTERN_CODE_SECOND_ADDR) begin
                cfg_next.pattern_code_b = wdata[CODE_POS +: 8];
            end else if (waddr == QUAD_GAIN_CTRL_ADDR) begin
                cfg_next.quad_gain = wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || pin_reset) begin
            cfg_reg <= '0;
            cfg_reg.drive <= '{DRIVE_DEFAULT, DRIVE_DEFAULT, DRIVE_DEFAULT};
            cfg_reg.term <= '{TERM_DEFAULT, TERM_DEFAULT, TERM_DEFAULT};
            cfg_reg.pattern_code_a <= CODE_DEFAULT;
            cfg_reg.pattern_code_b <= CODE_DEFAULT;
            cfg_reg.quad_gain <= {GAIN_UNITY, GAIN_UNITY, GAIN_UNITY, GAIN_UNITY};
            soft_reset_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            soft_reset_reg <= soft_reset_next;
        end
    end

    // Derived outputs, all registered
    lvds_code_t term_next;
    logic sleep_next;
    logic power_down_next;
    pattern_t pattern_sel;
    logic [7:0] ramp_reg;
    logic [7:0] ramp_next;
    logic phase_reg;
    logic phase_next;
    logic [7:0] data_next;
    logic is_pattern_next;
    lvds_code_t term_reg;
    logic sleep_reg;
    logic power_down_reg;
    logic [7:0] data_reg;
    logic is_pattern_reg;

    always_comb begin
        // Codes are meaningless with termination off, so they are masked
        term_next = cfg_reg.term_enable ? cfg_reg.term : '0;
        sleep_next = cfg_reg.sleep_bit;
        power_down_next = cfg_reg.power_down_bit;
        case (cfg_reg.powerdown_pin_function)
            PIN_POWER_DOWN: power_down_next = power_down_next | pin_power;
            PIN_SLEEP: sleep_next = sleep_next | pin_power;
            default: sleep_next = sleep_next;
        endcase
        // Ramp outranks the others if the host sets more than one
        if (cfg_reg.ramp_enable) begin
            pattern_sel = PAT_RAMP;
        end else if (cfg_reg.alternate_enable) begin
            pattern_sel = PAT_ALTERNATE;
        end else if (cfg_reg.constant_enable) begin
            pattern_sel = PAT_CONSTANT;
        end else begin
            pattern_sel = PAT_NONE;
        end
        ramp_next = ramp_reg + 8'h01;
        phase_next = ~phase_reg;
        is_pattern_next = pattern_sel != PAT_NONE;
        case (pattern_sel)
            PAT_RAMP: data_next = ramp_reg;
            PAT_ALTERNATE: data_next = phase_reg ? cfg_reg.pattern_code_b
                                                 : cfg_reg.pattern_code_a;
            PAT_CONSTANT: data_next = cfg_reg.pattern_code_a;
            default: data_next = conversion_data;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            term_reg <= '0;
            sleep_reg <= 1'b0;
            power_down_reg <= 1'b0;
            ramp_reg <= 8'h00;
            phase_reg <= 1'b0;
            data_reg <= 8'h00;
            is_pattern_reg <= 1'b0;
        end else begin
            term_reg <= term_next;
            sleep_reg <= sleep_next;
            power_down_reg <= power_down_next;
            ramp_reg <= ramp_next;
            phase_reg <= phase_next;
            data_reg <= data_next;
            is_pattern_reg <= is_pattern_next;
        end
    end

    assign config_out = cfg_reg;
    assign term_applied = term_reg;
    assign device_sleep = sleep_reg;
    assign device_power_down = power_down_reg;
    assign output_data = data_reg;
    assign output_is_pattern = is_pattern_reg;

endmodule

// *** design/serial_frame_rx.sv ***
/*
  Serial write port, link side: shifts 24-bit frames in on the serial clock
  and hands each complete frame over with a toggle.
  Assumes the serial clock runs only while the select is low; a high select
  clears the bit count without any clock edge. Assumes link_reset is raised
  while the serial clock is stopped.
*/
`timescale 1ns/1ns
module serial_frame_rx (
    input wire logic serial_clk,
    input wire logic link_reset,
    input wire logic serial_select_low,
    input wire logic serial_data_in,
    output adc_cfg_pkg::frame_t frame,
    output logic frame_toggle
);
    import adc_cfg_pkg::*;

    logic [4:0] count_reg;
    logic [4:0] count_next;
    logic [22:0] shift_reg;
    logic [22:0] shift_next;
    frame_t frame_reg;
    frame_t frame_next;
    logic toggle_reg;
    logic toggle_next;

    always_comb begin
        count_next = count_reg;
        shift_next = shift_reg;
        frame_next = frame_reg;
        toggle_next = toggle_reg;
        // Bits past the first word of a select pulse are dropped
        if (count_reg < FRAME_FULL) begin
            count_next = count_reg + 5'h01;
            shift_next = {shift_reg[21:0], serial_data_in};
        end
        // Address first, most significant bit first
        if (count_reg == FRAME_LAST) begin
            frame_next = {shift_reg, serial_data_in};
            toggle_next = ~toggle_reg;
        end
    end

    // Frame signal ends the count, since the clock stops between frames
    always_ff @(posedge serial_clk or posedge serial_select_low) begin
        if (serial_select_low) begin
            count_reg <= 5'h00;
            shift_reg <= 23'h000000;
        end else begin
            count_reg <= count_next;
            shift_reg <= shift_next;
        end
    end

    // Handed-over word stays put until the next full frame
    // Known start value keeps the ref-side edge detector in step
    always_ff @(posedge serial_clk or posedge link_reset) begin
        if (link_reset) begin
            frame_reg <= '0;
            toggle_reg <= 1'b0;
        end else begin
            frame_reg <= frame_next;
            toggle_reg <= toggle_next;
        end
    end

    assign frame = frame_reg;
    assign frame_toggle = toggle_reg;

endmodule
